// File: hw/scr_regs.svh
// Purpose: Register offsets, field positions and reset values
// Assumes: Included by the scanner command register bank only
// Notes:   Definitions only
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// Register offsets on the host byte port
`define SCR_OFS_TARGET    8'h03
`define SCR_OFS_ADDR_HI   8'h04
`define SCR_OFS_ADDR_LO   8'h05
`define SCR_OFS_DATA      8'h06
`define SCR_OFS_COMMAND   8'h07
`define SCR_OFS_MCLK_DIV  8'h08

// Target select fields
`define SCR_TGT_SEL_BIT   0
`define SCR_TGT_COL_LSB   1
`define SCR_TGT_COL_MSB   2

// Upper address register fields
`define SCR_AHI_ADDR_MSB  4
`define SCR_AHI_DIR_BIT   5

// Command register fields and codes
`define SCR_CMD_CODE_MSB  1
`define SCR_CMD_STBY_BIT  2
`define SCR_CMD_RST_BIT   3
`define SCR_CMD_IDLE      2'h0
`define SCR_CMD_FWD       2'h1
`define SCR_CMD_REV       2'h2
`define SCR_CMD_SCAN      2'h3

// Divider code field
`define SCR_DIV_CODE_MSB  5

// Reset values
`define SCR_RST_BYTE      8'h00
`define SCR_RST_PHASES    4'h0

// Full-step phase patterns, indexed by step position
`define SCR_PH_0          4'h9
`define SCR_PH_1          4'hc
`define SCR_PH_2          4'h6
`define SCR_PH_3          4'h3

`endif

// File: hw/scr_pkg.sv
// Purpose: Shared types of the scanner command register bank
// Assumes: Nothing beyond the register header
// Notes:   Types only; numbers live in scr_regs.svh
package scr_pkg;

   // Indirect store request toward gamma tables or coefficient SRAM
   typedef struct packed {
      logic        valid;   // One-cycle transfer strobe
      logic        we;      // High for a write
      logic        coef;    // High selects the coefficient store
      logic [1:0]  color;   // Gamma colour, 0 red 1 green 2 blue
      logic [12:0] addr;    // Byte or word address
      logic [7:0]  wdata;   // Write byte
   } scr_mem_req_s;

   // Scan and motor sequencing
   typedef enum logic [1:0] {
      st_idle,
      st_feed,
      st_scan,
      st_finish
   } scr_state_e;

endpackage

// File: hw/scr_command_dataport.sv
// Purpose: Host command, clock divider and indirect access registers
// Assumes: One clock is the crystal clock; inputs synchronous
// Notes:   Read data valid in the cycle after the read strobe only
//
// Overview of operation
// - Target picks gamma or coefficient, and colour
// - Single-channel mode A takes external colour
// - Upper address bit five picks read/write
// - Data window moves byte at current address
// - Address steps per byte gamma, two coef
// - Idle drops phases, finishes current line
// - Sensor clocks keep running while idle
// - Forward feed steps at fast feed rate
// - Reverse feed steps at same rate
// - Start scan resets pointers then acquires
// - Standby freezes internal clocks, oscillator runs
// - Standby powers down analog circuitry
// - Reset bit holds reset until cleared
// - Master clock is crystal over half-step ratio
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_command_dataport #(
   parameter int STEP_W = 16     // Width of the fast feed step size
)(
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // Host register port
   input  wire logic [7:0]           addr,
   input  wire logic [7:0]           wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [7:0]           rdata,
   // Configuration held elsewhere in the device
   input  wire logic                 mode_a_enable,
   input  wire logic [1:0]           mode_a_color,
   input  wire logic [STEP_W-1:0]    fast_feed_step,
   // Indirect store port
   output scr_pkg::scr_mem_req_s     mem_req,
   input  wire logic [7:0]           mem_rdata,
   // Scan pipeline
   input  wire logic                 line_end,
   output logic                      pointer_reset,
   output logic                      scan_active,
   // Motor
   output logic      [3:0]           motor_phase,
   output logic                      motor_reverse,
   // Clocks and power
   output logic                      sensor_clk_run,
   output logic                      osc_enable,
   output logic                      clocks_frozen,
   output logic                      analog_power_down,
   output logic                      soft_reset,
   output logic                      mclk_tick
);
   import scr_pkg::*;

   // Refuse widths the step counter cannot serve
   initial
   begin
      if (STEP_W < 2 || STEP_W > 24)
         $error("scr_command_dataport: STEP_W out of range");
   end

   // Host visible registers
   logic [7:0]  target_reg;      // Target and colour select
   logic [7:0]  addr_hi_reg;     // Direction and upper address
   logic [7:0]  addr_lo_reg;     // Lower address
   logic [7:0]  command_reg;     // Command, standby and reset
   logic [7:0]  mclk_div_reg;    // Divider code
   logic        byte_phase_reg;  // Second byte of a coefficient pair
   logic [7:0]  rdata_reg;       // Registered read answer

   // Motor and scan state
   scr_state_e        state_reg;
   logic [STEP_W-1:0] step_cnt_reg;   // Cycles since the last step
   logic [1:0]        step_pos_reg;   // Position in the phase pattern
   logic [3:0]        phase_reg;      // Phase outputs
   logic              reverse_reg;    // Feed direction
   logic              ptr_rst_reg;    // Pointer reset pulse
   logic [7:0]        div_acc_reg;    // Fractional divider accumulator
   logic              tick_reg;       // Master clock enable pulse
   scr_mem_req_s      mem_req_reg;    // Registered store request

   // Decoded fields
   logic [1:0]  cmd_code;
   logic        standby;
   logic        in_reset;
   logic        is_coef;
   logic        dir_read;
   logic [12:0] ind_addr;
   logic [12:0] ind_addr_next;
   logic        data_rd;
   logic        data_wr;
   logic        xfer;
   logic [7:0]  div_limit;
   logic [7:0]  div_sum;

   // Register select; used by both the write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Phase pattern for a step position
   function automatic logic [3:0] phase_of(input logic [1:0] pos);
      case (pos)
         2'h0:    phase_of = `SCR_PH_0;
         2'h1:    phase_of = `SCR_PH_1;
         2'h2:    phase_of = `SCR_PH_2;
         default: phase_of = `SCR_PH_3;
      endcase
   endfunction

   // Field extraction
   assign cmd_code = command_reg[`SCR_CMD_CODE_MSB:0];
   assign standby  = command_reg[`SCR_CMD_STBY_BIT];
   assign in_reset = command_reg[`SCR_CMD_RST_BIT];
   assign is_coef  = target_reg[`SCR_TGT_SEL_BIT];
   assign dir_read = addr_hi_reg[`SCR_AHI_DIR_BIT];
   assign ind_addr = {addr_hi_reg[`SCR_AHI_ADDR_MSB:0], addr_lo_reg};

   // Window accesses transfer only in the direction announced
   assign data_rd = rd && hit(addr, `SCR_OFS_DATA) && dir_read;
   assign data_wr = wr && hit(addr, `SCR_OFS_DATA) && !dir_read;
   assign xfer    = data_rd || data_wr;

   // Range is the host's duty; the counter just wraps at 13 bits
   assign ind_addr_next = ind_addr + 13'h0001;

   // Host writes to the direct registers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         target_reg   <= `SCR_RST_BYTE;
         command_reg  <= `SCR_RST_BYTE;
         mclk_div_reg <= `SCR_RST_BYTE;
      end
      else if (wr)
      begin
         // Decode by offset
         if (hit(addr, `SCR_OFS_TARGET))
            target_reg <= wdata;
         else if (hit(addr, `SCR_OFS_COMMAND))
            command_reg <= wdata;
         else if (hit(addr, `SCR_OFS_MCLK_DIV))
            mclk_div_reg <= wdata;
      end
   end

   // Address pair, written by the host or advanced by transfers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         addr_hi_reg    <= `SCR_RST_BYTE;
         addr_lo_reg    <= `SCR_RST_BYTE;
         byte_phase_reg <= 1'b0;
      end
      else if (wr && hit(addr, `SCR_OFS_ADDR_HI))
      begin
         // New address restarts the coefficient byte pair
         addr_hi_reg    <= wdata;
         byte_phase_reg <= 1'b0;
      end
      else if (wr && hit(addr, `SCR_OFS_ADDR_LO))
      begin
         addr_lo_reg    <= wdata;
         byte_phase_reg <= 1'b0;
      end
      else if (xfer)
      begin
         // Gamma steps every byte, coefficients every second byte
         if (!is_coef || byte_phase_reg)
         begin
            addr_hi_reg[`SCR_AHI_ADDR_MSB:0] <= ind_addr_next[12:8];
            addr_lo_reg <= ind_addr_next[7:0];
         end
         byte_phase_reg <= is_coef && !byte_phase_reg;
      end
   end

   // Store request, one cycle per window transfer
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         mem_req_reg <= '0;
      else
      begin
         mem_req_reg.valid <= xfer;
         mem_req_reg.we    <= data_wr;
         mem_req_reg.coef  <= is_coef;
         mem_req_reg.addr  <= ind_addr;
         mem_req_reg.wdata <= wdata;
         // Mode A overrides the colour field
         if (mode_a_enable)
            mem_req_reg.color <= mode_a_color;
         else
            mem_req_reg.color <=
               target_reg[`SCR_TGT_COL_MSB:`SCR_TGT_COL_LSB];
      end
   end

   // Read answer; the store answers combinationally on its address
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         rdata_reg <= `SCR_RST_BYTE;
      else if (!rd)
         rdata_reg <= `SCR_RST_BYTE;
      else if (hit(addr, `SCR_OFS_TARGET))
         rdata_reg <= target_reg;
      else if (hit(addr, `SCR_OFS_ADDR_HI))
         rdata_reg <= addr_hi_reg;
      else if (hit(addr, `SCR_OFS_ADDR_LO))
         rdata_reg <= addr_lo_reg;
      else if (hit(addr, `SCR_OFS_DATA))
         rdata_reg <= dir_read ? mem_rdata : `SCR_RST_BYTE;
      else if (hit(addr, `SCR_OFS_COMMAND))
         rdata_reg <= command_reg;
      else if (hit(addr, `SCR_OFS_MCLK_DIV))
         rdata_reg <= mclk_div_reg;
      else
         rdata_reg <= `SCR_RST_BYTE;   // Unmapped reads as zero
   end

   // Fractional divider: ratio is (code + 2) / 2, so add two per cycle
   assign div_limit = {2'b00, mclk_div_reg[`SCR_DIV_CODE_MSB:0]} + 8'h02;
   assign div_sum   = div_acc_reg + 8'h02;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         div_acc_reg <= `SCR_RST_BYTE;
         tick_reg    <= 1'b0;
      end
      else if (standby || in_reset)
      begin
         // Frozen clocks or reset clear the divider and stop ticks
         div_acc_reg <= `SCR_RST_BYTE;
         tick_reg    <= 1'b0;
      end
      else if (div_sum >= div_limit)
      begin
         div_acc_reg <= div_sum - div_limit;
         tick_reg    <= 1'b1;
      end
      else
      begin
         div_acc_reg <= div_sum;
         tick_reg    <= 1'b0;
      end
   end

   // Scan and feed sequencer
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg   <= st_idle;
         ptr_rst_reg <= 1'b0;
         reverse_reg <= 1'b0;
      end
      else if (in_reset)
      begin
         // Held in reset until the host clears the bit
         state_reg   <= st_idle;
         ptr_rst_reg <= 1'b0;
         reverse_reg <= 1'b0;
      end
      else if (!standby)
      begin
         ptr_rst_reg <= 1'b0;
         case (state_reg)
            st_idle:
            begin
               if (cmd_code == `SCR_CMD_SCAN)
               begin
                  ptr_rst_reg <= 1'b1;
                  state_reg   <= st_scan;
               end
               else if (cmd_code == `SCR_CMD_FWD)
               begin
                  reverse_reg <= 1'b0;
                  state_reg   <= st_feed;
               end
               else if (cmd_code == `SCR_CMD_REV)
               begin
                  reverse_reg <= 1'b1;
                  state_reg   <= st_feed;
               end
            end
            st_feed:
            begin
               // Any other code ends the feed at once
               if (cmd_code == `SCR_CMD_FWD)
                  reverse_reg <= 1'b0;
               else if (cmd_code == `SCR_CMD_REV)
                  reverse_reg <= 1'b1;
               else
                  state_reg <= st_idle;
            end
            st_scan:
            begin
               if (cmd_code != `SCR_CMD_SCAN)
                  state_reg <= st_finish;
            end
            st_finish:
            begin
               // Let the line in progress complete
               if (line_end)
                  state_reg <= st_idle;
            end
            default:
               state_reg <= st_idle;
         endcase
      end
   end

   // Fast feed stepping and phase outputs
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         step_cnt_reg <= '0;
         step_pos_reg <= 2'h0;
         phase_reg    <= `SCR_RST_PHASES;
      end
      else if (in_reset || cmd_code == `SCR_CMD_IDLE)
      begin
         step_cnt_reg <= '0;
         phase_reg    <= `SCR_RST_PHASES;
      end
      else if (!standby && state_reg == st_feed)
      begin
         phase_reg <= phase_of(step_pos_reg);
         // Step when the count of cycles reaches the step size
         if (step_cnt_reg + 1'b1 >= fast_feed_step)
         begin
            step_cnt_reg <= '0;
            if (reverse_reg)
               step_pos_reg <= step_pos_reg - 2'h1;
            else
               step_pos_reg <= step_pos_reg + 2'h1;
         end
         else
            step_cnt_reg <= step_cnt_reg + 1'b1;
      end
   end

   // Outputs
   assign rdata             = rdata_reg;
   assign mem_req           = mem_req_reg;
   assign pointer_reset     = ptr_rst_reg;
   assign scan_active       = (state_reg == st_scan) ||
                              (state_reg == st_finish);
   assign motor_phase       = phase_reg;
   assign motor_reverse     = reverse_reg;
   // Sensor clocks stop only for standby or reset, never for idle
   assign sensor_clk_run    = !standby && !in_reset;
   assign osc_enable        = 1'b1;
   assign clocks_frozen     = standby;
   assign analog_power_down = standby;
   assign soft_reset        = in_reset;
   assign mclk_tick         = tick_reg;

endmodule

// File: tb/scr_command_dataport_sva.sv
// Purpose: Port checks for the command and indirect access bank
// Assumes: Sees only top ports; one clock domain
// Notes:   Bind statement follows the module
`timescale 1ns/1ps
module scr_command_dataport_sva
   import scr_pkg::*;
#(
   parameter int STEP_W = 16   // Fast feed step width
)(
   // Clock and reset
   input wire logic               clock,
   input wire logic               nrst,
   // Host port
   input wire logic [7:0]         addr,
   input wire logic [7:0]         wdata,
   input wire logic               wr,
   input wire logic               rd,
   input wire logic [7:0]         rdata,
   // Side inputs
   input wire logic               mode_a_enable,
   input wire logic [1:0]         mode_a_color,
   input wire logic               line_end,
   // Observed outputs
   input wire scr_mem_req_s       mem_req,
   input wire logic               pointer_reset,
   input wire logic               scan_active,
   input wire logic [3:0]         motor_phase,
   input wire logic               motor_reverse,
   input wire logic               sensor_clk_run,
   input wire logic               osc_enable,
   input wire logic               clocks_frozen,
   input wire logic               analog_power_down,
   input wire logic               soft_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // Scan start pulse lasts one cycle with scan running
   sequence s_started;
      scan_active ##1 !pointer_reset;
   endsequence

   property p_rd_idle;
      !$past(rd) |-> rdata == 8'h00;
   endproperty
   // The written byte is the one on the bus a cycle earlier
   property p_wr_req;
      mem_req.valid && mem_req.we
         |-> $past(wr && addr == 8'h06) && mem_req.wdata == $past(wdata);
   endproperty
   property p_rd_req;
      mem_req.valid && !mem_req.we |-> $past(rd && addr == 8'h06);
   endproperty
   property p_mode_a;
      mem_req.valid && !mem_req.coef && $past(mode_a_enable)
         |-> mem_req.color == $past(mode_a_color);
   endproperty
   // Any command without standby or reset, idle too, keeps sensor clocks
   property p_run;
      $past(wr && addr == 8'h07 && wdata[3:2] == 2'b00) |-> sensor_clk_run;
   endproperty
   // Standby follows the written bit; the oscillator never stops
   property p_stby;
      $past(wr && addr == 8'h07)
         |-> clocks_frozen == $past(wdata[2]) && osc_enable
             && analog_power_down == $past(wdata[2]);
   endproperty
   property p_soft;
      soft_reset |=> motor_phase == 4'h0;
   endproperty
   property p_start;
      pointer_reset |-> s_started;
   endproperty
   // Direction decides the successor of the first pattern
   property p_step;
      $past(motor_phase) == 4'h9 && motor_phase != 4'h9
         && motor_phase != 4'h0
         |-> motor_phase == (motor_reverse ? 4'h3 : 4'hc);
   endproperty
   // Scan only ends at a line end, unless reset cuts it
   property p_line;
      $fell(scan_active) |-> $past(line_end) || $past(soft_reset);
   endproperty

   a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
   a_wr_req: assert property (p_wr_req) else $error("bad write");
   a_rd_req: assert property (p_rd_req) else $error("bad read req");
   a_mode_a: assert property (p_mode_a) else $error("bad colour");
   a_run: assert property (p_run) else $error("sensor stopped");
   a_stby: assert property (p_stby) else $error("bad standby");
   a_soft: assert property (p_soft) else $error("phases on");
   a_start: assert property (p_start) else $error("bad start");
   a_step: assert property (p_step) else $error("bad step");
   a_line: assert property (p_line) else $error("early stop");
endmodule

bind scr_command_dataport scr_command_dataport_sva #(.STEP_W(STEP_W)) u_sva (
   .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .mode_a_enable(mode_a_enable),
   .mode_a_color(mode_a_color), .line_end(line_end), .mem_req(mem_req),
   .pointer_reset(pointer_reset), .scan_active(scan_active),
   .motor_phase(motor_phase), .motor_reverse(motor_reverse),
   .sensor_clk_run(sensor_clk_run), .osc_enable(osc_enable),
   .clocks_frozen(clocks_frozen), .analog_power_down(analog_power_down),
   .soft_reset(soft_reset));

// File: tb/scr_store_model.sv
// Purpose: Gamma and coefficient store behind the indirect port
// Assumes: Bench names the address it expects a read at
// Notes:   Read answer is combinational on that key
`timescale 1ns/1ps
module scr_store_model
   import scr_pkg::*;
(
   input wire logic               clock,
   input wire scr_pkg::scr_mem_req_s mem_req,
   input wire logic [15:0]        peek_key,  // {coef, colour, address}
   output logic [7:0]             mem_rdata
);
   logic [7:0] mem [0:65535];  // Unwritten places read unknown

   // Store each written byte at its target and address
   always_ff @(posedge clock)
   begin
      if (mem_req.valid && mem_req.we)
         mem[{mem_req.coef, mem_req.color, mem_req.addr}] <=
            mem_req.wdata;
   end

   assign mem_rdata = mem[peek_key];
endmodule

// File: tb/tb_scanner_command_and_dataport_regs.sv
// Purpose: Register-level test of the command and indirect bank
// Assumes: Host port answers reads one cycle later
// Notes:   Every wait is bounded
`timescale 1ns/1ps
module tb_scanner_command_and_dataport_regs;
   import scr_pkg::*;
   logic          clock, nrst, wr, rd, mode_a_enable, line_end;
   logic [7:0]    addr, wdata, rdata, mem_rdata, d;
   logic [1:0]    mode_a_color;
   logic [15:0]   fast_feed_step, peek_key;
   logic [3:0]    motor_phase;
   logic          pointer_reset, scan_active, motor_reverse, mclk_tick;
   logic          sensor_clk_run, osc_enable, clocks_frozen;
   logic          analog_power_down, soft_reset;
   scr_mem_req_s  mem_req;
   scr_mem_req_s  q[$];        // Requests seen on the store port
   int            fail_count, cmp_count, pr_cnt, i, k, n, g;
   int            codes[4] = '{0, 1, 6, 63};

   scr_command_dataport #(.STEP_W(16)) dut_u (.clock(clock), .nrst(nrst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .mode_a_enable(mode_a_enable), .mode_a_color(mode_a_color),
      .fast_feed_step(fast_feed_step), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .line_end(line_end),
      .pointer_reset(pointer_reset), .scan_active(scan_active),
      .motor_phase(motor_phase), .motor_reverse(motor_reverse),
      .sensor_clk_run(sensor_clk_run), .osc_enable(osc_enable),
      .clocks_frozen(clocks_frozen), .analog_power_down(analog_power_down),
      .soft_reset(soft_reset), .mclk_tick(mclk_tick));
   scr_store_model store_u (.clock(clock), .mem_req(mem_req),
      .peek_key(peek_key), .mem_rdata(mem_rdata));

   initial clock = 1'b0;
   always #2 clock = ~clock;

   // Record store requests and scan start pulses; sampled mid-cycle so
   // a task resuming on the rising edge never races the record
   always @(negedge clock)
   begin
      if (mem_req.valid === 1'b1)
         q.push_back(mem_req);
      if (pointer_reset === 1'b1)
         pr_cnt++;
   end

   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // One-cycle strobes, a cycle apart, so no signal is set twice at once
   task automatic wreg(logic [7:0] a, logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rreg(logic [7:0] a, output logic [7:0] v);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge clock);
   endtask

   // Cycles before the fifth phase change, bounded; five changes turn
   // the pattern fully so reverse later starts from the first pattern
   task automatic step_gap(output int gap);
      logic [3:0] p;
      for (int r = 0; r < 5; r++)
      begin
         #1 p = motor_phase;
         gap = 0;
         while (motor_phase === p && gap < 60)
         begin
            @(posedge clock);
            #1 gap++;
         end
      end
      if (gap >= 60)
      begin
         fail_count++;
         final_report();
      end
   endtask

   initial
   begin
      {wr, rd, addr, wdata, mode_a_enable, mode_a_color} = '0;
      {line_end, peek_key, nrst} = '0;
      fast_feed_step = 16'h0004;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      // Reset contents and plain read back, unmapped place too
      for (i = 3; i <= 10; i++)
      begin
         rreg(i[7:0], d);
         chk("reset", d, 16'h0000);
      end
      wreg(8'h0a, 8'hff);
      rreg(8'h0a, d);
      chk("unmapped", d, 16'h0000);
      wreg(8'h03, 8'h05);
      rreg(8'h03, d);
      chk("target", d, 16'h0005);
      wreg(8'h05, 8'ha5);
      rreg(8'h05, d);
      chk("addr_lo", d, 16'h00a5);
      // Gamma writes to blue step one address per byte
      wreg(8'h03, 8'h04);
      wreg(8'h04, 8'h00);
      wreg(8'h05, 8'h10);
      q.delete();
      wreg(8'h06, 8'haa);
      wreg(8'h06, 8'hbb);
      chk("g_cnt", q.size(), 16'h0002);
      for (k = 0; k < 2; k++)
      begin
         chk("g_addr", q[k].addr, 16'h0010 + k);
         // Write, gamma, blue: four bits 1, 0, 10
         chk("g_tgt", {q[k].we, q[k].coef, q[k].color}, 16'h000a);
      end
      // Coefficients take two bytes per address
      wreg(8'h03, 8'h01);
      wreg(8'h04, 8'h01);
      wreg(8'h05, 8'h23);
      q.delete();
      for (k = 0; k < 4; k++)
         wreg(8'h06, 8'h30 + k[7:0]);
      for (k = 0; k < 4; k++)
         chk("c_addr", {q[k].coef, q[k].addr}, 16'h2123 + k / 2);
      // Read direction: a write is refused, reads return stored bytes
      wreg(8'h03, 8'h04);
      wreg(8'h04, 8'h20);
      wreg(8'h05, 8'h10);
      q.delete();
      wreg(8'h06, 8'h77);
      for (k = 0; k < 2; k++)
      begin
         peek_key <= {1'b0, 2'd2, 13'h0010 + k[12:0]};
         rreg(8'h06, d);
         chk("rd_data", d, k ? 16'h00bb : 16'h00aa);
      end
      chk("rd_reqs", q.size(), 16'h0002);
      // Mode A takes the colour from outside
      mode_a_enable <= 1'b1;
      mode_a_color <= 2'd1;
      wreg(8'h04, 8'h00);
      q.delete();
      wreg(8'h06, 8'h11);
      chk("mode_a", q[0].color, 16'h0001);
      mode_a_enable <= 1'b0;
      // Feed forward and back at the fast feed rate
      for (k = 1; k <= 2; k++)
      begin
         wreg(8'h07, k[7:0]);
         step_gap(g);
         chk("step_gap", g, 16'h0004);
         chk("reverse", motor_reverse, k - 1);
         wreg(8'h07, 8'h00);
         @(posedge clock);
         #1 chk("idle_ph", motor_phase, 16'h0000);
      end
      // Scan start, then idle waits for the line end
      pr_cnt = 0;
      wreg(8'h07, 8'h03);
      repeat (3) @(posedge clock);
      chk("ptr_rst", pr_cnt, 16'h0001);
      wreg(8'h07, 8'h00);
      repeat (4) @(posedge clock);
      #1 chk("finish", scan_active, 16'h0001);
      chk("sens_run", sensor_clk_run, 16'h0001);
      @(posedge clock);
      line_end <= 1'b1;
      @(posedge clock);
      line_end <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("stopped", scan_active, 16'h0000);
      // Standby and back
      wreg(8'h07, 8'h04);
      #1 chk("stby", {clocks_frozen, analog_power_down, osc_enable,
         sensor_clk_run}, 16'h000e);
      wreg(8'h07, 8'h00);
      #1 chk("wake", {clocks_frozen, analog_power_down}, 16'h0000);
      // Reset bit holds until written back to zero
      wreg(8'h07, 8'h01);
      repeat (10) @(posedge clock);
      wreg(8'h07, 8'h09);
      repeat (2) @(posedge clock);
      #1 chk("in_rst", {soft_reset, motor_phase}, 16'h0010);
      wreg(8'h08, 8'h05);
      rreg(8'h08, d);
      chk("rst_wr", d, 16'h0005);
      wreg(8'h07, 8'h00);
      #1 chk("out_rst", soft_reset, 16'h0000);
      // Twenty ticks in ten times (code + 2) cycles
      for (k = 0; k < 4; k++)
      begin
         wreg(8'h08, codes[k][7:0]);
         repeat (70) @(posedge clock);
         n = 0;
         for (i = 0; i < 10 * (codes[k] + 2); i++)
         begin
            @(posedge clock);
            #1 n += mclk_tick;
         end
         chk("mclk", n, 16'h0014);
      end
      final_report();
   end
endmodule
